// ===== inc/smpm_pkg.sv
// shared constants and types for the switch monitor power-mode controller
package smpm_pkg;
    localparam int SYS_CLK_MHZ = 250;
    localparam int FUSE_READ_US = 50;
    localparam int FUSE_READ_CYC = FUSE_READ_US * SYS_CLK_MHZ;
    localparam int SUSTAIN_US = 270;
    localparam int SUSTAIN_CYC = SUSTAIN_US * SYS_CLK_MHZ;
    localparam int SLOW_CLK_KHZ = 192;
    localparam int SLOW_DIV = (SYS_CLK_MHZ * 1000) / SLOW_CLK_KHZ;
    localparam int ACTIVE_POLL_TICKS = 4;
    localparam logic [3:0] WET_REDUCED = 4'h0;
    localparam int NUM_GND_INPUTS = 21;
    localparam int NUM_PROG_INPUTS = 12;

    typedef enum logic [2:0] {
        SMPM_RESET,
        SMPM_UV_LOCK,
        SMPM_FUSE_READ,
        SMPM_NORMAL,
        SMPM_LOW_POWER,
        SMPM_POLL,
        SMPM_SUPPLY_CHECK
    } smpm_state_t;
endpackage : smpm_pkg

// ===== inc/smpm_wake_if.sv
// synchronised wake event interface between top and edge detector
`timescale 1ns/1ps
interface smpm_wake_if;
    logic slow_tick;
    logic wake_fall;
    logic int_fall;
    logic cs_fall;
    modport det (input slow_tick, output wake_fall, output int_fall, output cs_fall);
    modport top (output slow_tick, input wake_fall, input int_fall, input cs_fall);
endinterface : smpm_wake_if

// ===== rtl/smpm_edge_sync.sv
// three-stage pin synchroniser with falling-edge detection on slow ticks
`timescale 1ns/1ps
module smpm_edge_sync
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [2:0] pins_in,
    smpm_wake_if.det wif
);
    logic [2:0] s1, s2, s3, last;
    logic [2:0] next_last;
    logic [2:0] fall;

    always_comb
    begin
        next_last = last;
        fall = 3'h0;
        // only agreed levels count; sampled on the slow tick
        if (wif.slow_tick && (s2 == s3))
        begin
            fall = last & ~s3;
            next_last = s3;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1 <= 3'h7;
            s2 <= 3'h7;
            s3 <= 3'h7;
            last <= 3'h7;
        end
        else
        begin
            s1 <= pins_in;
            s2 <= s1;
            s3 <= s2;
            last <= next_last;
        end
    end

    assign wif.wake_fall = fall[0];
    assign wif.int_fall = fall[1];
    assign wif.cs_fall = fall[2];
endmodule : smpm_edge_sync

// ===== rtl/smpm_power_fsm.sv
// operating-state controller for the switch monitor
`timescale 1ns/1ps
module smpm_power_fsm
    import smpm_pkg::*;
#(
    parameter int NG = NUM_GND_INPUTS,
    parameter int NP = NUM_PROG_INPUTS,
    parameter int FUSE_CYC = FUSE_READ_CYC,
    parameter int SUST_CYC = SUSTAIN_CYC
)
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic CORE_POR_IN,
    input wire logic BATTERY_SUPPLY_OK_IN,
    input wire logic IO_SUPPLY_OK_IN,
    input wire logic LPM_CMD_IN,
    input wire logic WAKE_SUPPLY_CHECK_IN,
    input wire logic [15:0] INT_TIMER_TICKS_IN,
    input wire logic [15:0] POLL_TIMER_TICKS_IN,
    input wire logic [NG+NP-1:0] WAKE_ENABLE_IN,
    input wire logic [NG+NP-1:0] COMPARATOR_ONLY_IN,
    input wire logic [NP-1:0] BATTERY_SWITCH_CONFIG_IN,
    input wire logic [NG+NP-1:0] COMPARATOR_HIGH_IN,
    input wire logic THERMAL_LIMIT_CELLS_IN,
    input wire logic THERMAL_LIMIT_CLEAR_IN,
    input wire logic THERMAL_WARN_IN,
    input wire logic OVERVOLTAGE_IN,
    input wire logic SERIAL_ERROR_IN,
    input wire logic HASH_MISMATCH_IN,
    input wire logic [3:0] WETTING_LEVEL_IN,
    input wire logic WAKE_PIN_IN,
    input wire logic INT_PIN_IN,
    input wire logic CS_PIN_IN,
    output logic WAKE_PIN_OUT,
    output logic WAKE_PIN_OE_OUT,
    output logic [2:0] STATE_OUT,
    output logic SERIAL_ENABLE_OUT,
    output logic ANALOG_SELECT_ENABLE_OUT,
    output logic SOURCES_ENABLE_OUT,
    output logic FAST_OSC_ENABLE_OUT,
    output logic SLOW_OSC_ENABLE_OUT,
    output logic FAULT_DETECT_ENABLE_OUT,
    output logic [NG+NP-1:0] PULL_DOWN_OUT,
    output logic [NG+NP-1:0] SWITCH_CLOSED_OUT,
    output logic POLL_ACTIVE_OUT,
    output logic WAKE_REPORT_OUT,
    output logic INT_TIMER_WAKE_OUT,
    output logic THERMAL_LIMIT_FAULT_OUT,
    output logic THERMAL_WARNING_OUT,
    output logic [4:0] FAULT_FLAGS_OUT,
    output logic SUSTAIN_ACTIVE_OUT,
    output logic [3:0] WETTING_LEVEL_OUT
);
    localparam int NT = NG + NP;

    smpm_wake_if wif ();
    smpm_state_t state, next_state;
    logic [15:0] div, next_div;
    logic [15:0] int_cnt, next_int_cnt, poll_cnt, next_poll_cnt;
    logic [2:0] act_cnt, next_act_cnt;
    logic [31:0] cyc, next_cyc;
    logic [31:0] sust, next_sust;
    logic [NT-1:0] snap, next_snap, closed_now;
    logic wake_rep, next_wake_rep, tmr_wake, next_tmr_wake, via_wake, next_via_wake;
    logic thermal_limit_fault, next_thermal_limit_fault, twarn, next_twarn;
    logic [4:0] flt, next_flt;
    logic pin_edge, any_en, cmp_change, poll_change;
    logic slow_tick;

    // battery-switch inputs invert the comparator sense
    function automatic logic [NT-1:0] closed_of(input logic [NT-1:0] hi,
                                                input logic [NP-1:0] bsw);
        logic [NT-1:0] pd;
        pd = {bsw, {NG{1'b0}}};
        closed_of = (hi & pd) | (~hi & ~pd);
    endfunction : closed_of

    smpm_edge_sync u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .pins_in({CS_PIN_IN, INT_PIN_IN, WAKE_PIN_IN}),
        .wif(wif.det)
    );
    // common base tick from the slow clock rate
    assign slow_tick = (div == 16'(SLOW_DIV - 1));
    assign wif.slow_tick = slow_tick;

    always_comb
    begin
        closed_now = closed_of(COMPARATOR_HIGH_IN, BATTERY_SWITCH_CONFIG_IN);
        any_en = |WAKE_ENABLE_IN;
        cmp_change = |((closed_now ^ snap) & COMPARATOR_ONLY_IN & WAKE_ENABLE_IN);
        poll_change = |((closed_now ^ snap) & WAKE_ENABLE_IN);
        // in low power and polling a pin edge goes through the supply check state unless a timer or comparator wake wins
        pin_edge = wif.int_fall || wif.cs_fall || wif.wake_fall;
    end

    always_comb
    begin
        next_state = state;
        next_div = slow_tick ? 16'h0 : div + 16'h1;
        next_int_cnt = int_cnt;
        next_poll_cnt = poll_cnt;
        next_act_cnt = act_cnt;
        next_cyc = cyc;
        next_sust = sust;
        next_snap = snap;
        next_wake_rep = wake_rep;
        next_tmr_wake = tmr_wake;
        next_thermal_limit_fault = thermal_limit_fault;
        next_twarn = twarn;
        next_flt = flt;
        next_via_wake = via_wake;
        case (state)
            SMPM_RESET:
            begin
                if (!CORE_POR_IN)
                    next_state = SMPM_UV_LOCK;
            end
            SMPM_UV_LOCK:
            begin
                next_cyc = 32'h0;
                if (BATTERY_SUPPLY_OK_IN)
                    next_state = SMPM_FUSE_READ;
            end
            SMPM_FUSE_READ:
            begin
                next_cyc = cyc + 32'h1;
                if (cyc >= 32'(FUSE_CYC - 1))
                    next_state = SMPM_NORMAL;
            end
            SMPM_NORMAL:
            begin
                // faults sticky only while normal mode runs detection
                next_flt = flt | {OVERVOLTAGE_IN, THERMAL_WARN_IN, THERMAL_LIMIT_CELLS_IN,
                                  SERIAL_ERROR_IN, HASH_MISMATCH_IN};
                if (THERMAL_LIMIT_CELLS_IN)
                    next_thermal_limit_fault = 1'b1;
                else if (THERMAL_LIMIT_CLEAR_IN)
                    next_thermal_limit_fault = 1'b0;
                next_twarn = THERMAL_WARN_IN;
                if (sust != 32'h0)
                    next_sust = sust - 32'h1;
                if (LPM_CMD_IN)
                begin
                    next_state = SMPM_LOW_POWER;
                    next_snap = closed_now;
                    next_int_cnt = 16'h0;
                    next_poll_cnt = 16'h0;
                    next_wake_rep = 1'b0;
                    next_tmr_wake = 1'b0;
                end
            end
            SMPM_LOW_POWER, SMPM_POLL:
            begin
                if (slow_tick)
                begin
                    next_int_cnt = int_cnt + 16'h1;
                    if (any_en && BATTERY_SUPPLY_OK_IN)
                        next_poll_cnt = poll_cnt + 16'h1;
                end
                if (state == SMPM_POLL && slow_tick)
                    next_act_cnt = act_cnt + 3'h1;
                if (slow_tick && INT_TIMER_TICKS_IN != 16'h0
                    && int_cnt + 16'h1 >= INT_TIMER_TICKS_IN)
                begin
                    next_state = SMPM_NORMAL;
                    next_tmr_wake = 1'b1;
                    next_wake_rep = 1'b1;
                end
                else if (cmp_change)
                begin
                    next_state = SMPM_NORMAL;
                    next_wake_rep = 1'b1;
                    next_sust = 32'(SUST_CYC);
                end
                else if (pin_edge)
                begin
                    next_state = SMPM_SUPPLY_CHECK;
                    next_via_wake = wif.wake_fall;
                end
                else if (state == SMPM_LOW_POWER && slow_tick && any_en
                         && BATTERY_SUPPLY_OK_IN && POLL_TIMER_TICKS_IN != 16'h0
                         && poll_cnt + 16'h1 >= POLL_TIMER_TICKS_IN)
                begin
                    next_state = SMPM_POLL;
                    next_poll_cnt = 16'h0;
                    next_act_cnt = 3'h0;
                end
                else if (state == SMPM_POLL && !BATTERY_SUPPLY_OK_IN)
                begin
                    next_state = SMPM_LOW_POWER;
                end
                else if (state == SMPM_POLL && act_cnt == 3'(ACTIVE_POLL_TICKS))
                begin
                    next_state = poll_change ? SMPM_NORMAL : SMPM_LOW_POWER;
                    next_wake_rep = poll_change;
                    next_sust = poll_change ? 32'(SUST_CYC) : 32'h0;
                end
            end
            SMPM_SUPPLY_CHECK:
            begin
                // wake pin with check bit set wakes regardless of supply
                if (IO_SUPPLY_OK_IN || (WAKE_SUPPLY_CHECK_IN && via_wake))
                begin
                    next_state = SMPM_NORMAL;
                    next_wake_rep = 1'b1;
                end
                else
                    next_state = SMPM_LOW_POWER;
            end
            default: next_state = SMPM_RESET;
        endcase
        if (CORE_POR_IN)
            next_state = SMPM_RESET;
        else if (!BATTERY_SUPPLY_OK_IN && state inside {SMPM_FUSE_READ, SMPM_NORMAL})
            next_state = SMPM_UV_LOCK;
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            state <= SMPM_RESET;
            div <= 16'h0;
            int_cnt <= 16'h0;
            poll_cnt <= 16'h0;
            act_cnt <= 3'h0;
            cyc <= 32'h0;
            sust <= 32'h0;
            snap <= '0;
            wake_rep <= 1'b0;
            tmr_wake <= 1'b0;
            thermal_limit_fault <= 1'b0;
            twarn <= 1'b0;
            flt <= 5'h0;
            via_wake <= 1'b0;
        end
        else
        begin
            state <= next_state;
            div <= next_div;
            int_cnt <= next_int_cnt;
            poll_cnt <= next_poll_cnt;
            act_cnt <= next_act_cnt;
            cyc <= next_cyc;
            sust <= next_sust;
            snap <= next_snap;
            wake_rep <= next_wake_rep;
            tmr_wake <= next_tmr_wake;
            thermal_limit_fault <= next_thermal_limit_fault;
            twarn <= next_twarn;
            flt <= next_flt;
            via_wake <= next_via_wake;
        end
    end

    // output registers: mode outputs derived from next state so they track it exactly; pull-down and switch outputs registered from the inputs
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            WAKE_PIN_OUT <= 1'b0;
            WAKE_PIN_OE_OUT <= 1'b0;
            STATE_OUT <= 3'h0;
            SERIAL_ENABLE_OUT <= 1'b0;
            ANALOG_SELECT_ENABLE_OUT <= 1'b0;
            SOURCES_ENABLE_OUT <= 1'b0;
            FAST_OSC_ENABLE_OUT <= 1'b0;
            SLOW_OSC_ENABLE_OUT <= 1'b0;
            FAULT_DETECT_ENABLE_OUT <= 1'b0;
            PULL_DOWN_OUT <= '0;
            SWITCH_CLOSED_OUT <= '0;
            POLL_ACTIVE_OUT <= 1'b0;
            WAKE_REPORT_OUT <= 1'b0;
            INT_TIMER_WAKE_OUT <= 1'b0;
            THERMAL_LIMIT_FAULT_OUT <= 1'b0;
            THERMAL_WARNING_OUT <= 1'b0;
            FAULT_FLAGS_OUT <= 5'h0;
            SUSTAIN_ACTIVE_OUT <= 1'b0;
            WETTING_LEVEL_OUT <= 4'h0;
        end
        else
        begin
            WAKE_PIN_OUT <= 1'b0;
            // wake pin driven only in normal; released in every other state
            WAKE_PIN_OE_OUT <= next_state inside {SMPM_NORMAL};
            STATE_OUT <= 3'(next_state);
            SERIAL_ENABLE_OUT <= (next_state == SMPM_NORMAL);
            ANALOG_SELECT_ENABLE_OUT <= (next_state == SMPM_NORMAL);
            SOURCES_ENABLE_OUT <= next_state inside {SMPM_NORMAL, SMPM_POLL};
            FAST_OSC_ENABLE_OUT <= next_state inside {SMPM_UV_LOCK, SMPM_FUSE_READ,
                                                      SMPM_NORMAL};
            SLOW_OSC_ENABLE_OUT <= (next_state != SMPM_RESET);
            FAULT_DETECT_ENABLE_OUT <= (next_state == SMPM_NORMAL);
            PULL_DOWN_OUT <= {BATTERY_SWITCH_CONFIG_IN, {NG{1'b0}}};
            SWITCH_CLOSED_OUT <= closed_now;
            POLL_ACTIVE_OUT <= (next_state == SMPM_POLL);
            WAKE_REPORT_OUT <= next_wake_rep;
            INT_TIMER_WAKE_OUT <= next_tmr_wake;
            THERMAL_LIMIT_FAULT_OUT <= next_thermal_limit_fault;
            THERMAL_WARNING_OUT <= next_twarn;
            FAULT_FLAGS_OUT <= next_flt;
            SUSTAIN_ACTIVE_OUT <= (next_sust != 32'h0);
            // reduced wetting level while the thermal limit stands
            WETTING_LEVEL_OUT <= next_thermal_limit_fault ? WET_REDUCED : WETTING_LEVEL_IN;
        end
    end

    fuse_time_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state == SMPM_FUSE_READ ##1 state == SMPM_NORMAL) |-> $past(cyc) == 32'(FUSE_CYC - 1))
        else $error("fuse read left early");
    lpm_entry_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state == SMPM_LOW_POWER && $past(state) == SMPM_NORMAL) |-> $past(LPM_CMD_IN))
        else $error("low power entered without command");
    pin_release_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state == SMPM_LOW_POWER) |-> !WAKE_PIN_OE_OUT)
        else $error("wake pin driven in low power");
    pin_drive_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state == SMPM_NORMAL) |-> WAKE_PIN_OE_OUT && !WAKE_PIN_OUT)
        else $error("wake pin not low in normal");
    fast_osc_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state inside {SMPM_LOW_POWER, SMPM_POLL}) |-> !FAST_OSC_ENABLE_OUT
         && !FAULT_DETECT_ENABLE_OUT)
        else $error("fast clock or faults on in low power");
    serial_lock_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state == SMPM_UV_LOCK) |-> !SERIAL_ENABLE_OUT && !SOURCES_ENABLE_OUT)
        else $error("serial or sources on in lockout");
    poll_off_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (state == SMPM_LOW_POWER && WAKE_ENABLE_IN == '0) |=> state != SMPM_POLL)
        else $error("poll with all wakes disabled");
    wet_reduce_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        THERMAL_LIMIT_FAULT_OUT |-> WETTING_LEVEL_OUT == WET_REDUCED)
        else $error("wetting not reduced under thermal limit");
    por_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        CORE_POR_IN |=> state == SMPM_RESET)
        else $error("not held in reset");
    lpm_cover_c: cover property (@(posedge CLK_SYS_IN) state == SMPM_LOW_POWER);
    poll_cover_c: cover property (@(posedge CLK_SYS_IN) state == SMPM_POLL);
    wake_cover_c: cover property (@(posedge CLK_SYS_IN)
        state == SMPM_SUPPLY_CHECK ##1 state == SMPM_NORMAL);
endmodule : smpm_power_fsm

// ===== testbench/smpm_host_model.sv
// host controller model: serial low-power command and the wake-capable pins
`timescale 1ns/1ps
module smpm_host_model
    import smpm_pkg::*;
(
    input wire logic clk_in,
    input wire logic [2:0] state_in,
    input wire logic lpm_req_in,
    input wire logic wake_low_in,
    input wire logic int_low_in,
    input wire logic cs_low_in,
    input wire logic wake_oe_in,
    input wire logic wake_drv_in,
    output logic lpm_cmd_out,
    output logic wake_pin_out,
    output logic int_pin_out,
    output logic cs_pin_out
);
    // serial port is dead outside normal, so the command only goes out there
    always @(posedge clk_in)
        lpm_cmd_out <= lpm_req_in && (state_in == SMPM_NORMAL);
    // open-drain lines with pull-up: released means high, never the last value
    assign wake_pin_out = !((wake_oe_in && !wake_drv_in) || wake_low_in);
    assign int_pin_out = !int_low_in;
    assign cs_pin_out = !cs_low_in;
endmodule : smpm_host_model

// ===== testbench/smpm_power_fsm_tb_top.sv
// self-checking bench for the power-mode controller
`timescale 1ns/1ps
module smpm_power_fsm_tb_top;
    import smpm_pkg::*;
    localparam int FC = 20;
    localparam int SC = 20;
    localparam int NG = NUM_GND_INPUTS;
    localparam int NB = NUM_GND_INPUTS + NUM_PROG_INPUTS;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1, bat = 1'b0, io = 1'b1, sck = 1'b0, lpm_req = 1'b0;
    logic [15:0] itk = 16'h0000, ptk = 16'h0000;
    logic [NB-1:0] wen = '1, conly = '0, chi = '1;
    logic [NUM_PROG_INPUTS-1:0] bsw = '0;
    logic tcell = 1'b0, tclr = 1'b0, twarn = 1'b0, ov = 1'b0, serr = 1'b0, hash = 1'b0;
    logic [3:0] wet = 4'h0;
    logic wlow = 1'b0, ilow = 1'b0, clow = 1'b0;
    logic wpin, ipin, cpin, lcmd, woe, wdrv, ser_en, an_en, src_en, fosc, sosc, fden;
    logic pact, wrep, itw, tlf, twf, sus;
    logic [2:0] st;
    logic [NB-1:0] pdn, closed;
    logic [4:0] ff;
    logic [3:0] wout;
    int fails = 0, checked = 0, cyc = 0, n;
    always #2 clk = ~clk;
    smpm_host_model i_host (.clk_in(clk), .state_in(st), .lpm_req_in(lpm_req),
        .wake_low_in(wlow), .int_low_in(ilow), .cs_low_in(clow), .wake_oe_in(woe),
        .wake_drv_in(wdrv), .lpm_cmd_out(lcmd), .wake_pin_out(wpin), .int_pin_out(ipin),
        .cs_pin_out(cpin));
    smpm_power_fsm #(.FUSE_CYC(FC), .SUST_CYC(SC)) i_dut (.CLK_SYS_IN(clk), .RST_IN(rst),
        .CORE_POR_IN(por), .BATTERY_SUPPLY_OK_IN(bat), .IO_SUPPLY_OK_IN(io),
        .LPM_CMD_IN(lcmd), .WAKE_SUPPLY_CHECK_IN(sck), .INT_TIMER_TICKS_IN(itk),
        .POLL_TIMER_TICKS_IN(ptk), .WAKE_ENABLE_IN(wen), .COMPARATOR_ONLY_IN(conly),
        .BATTERY_SWITCH_CONFIG_IN(bsw), .COMPARATOR_HIGH_IN(chi),
        .THERMAL_LIMIT_CELLS_IN(tcell), .THERMAL_LIMIT_CLEAR_IN(tclr),
        .THERMAL_WARN_IN(twarn), .OVERVOLTAGE_IN(ov), .SERIAL_ERROR_IN(serr),
        .HASH_MISMATCH_IN(hash), .WETTING_LEVEL_IN(wet), .WAKE_PIN_IN(wpin),
        .INT_PIN_IN(ipin), .CS_PIN_IN(cpin), .WAKE_PIN_OUT(wdrv), .WAKE_PIN_OE_OUT(woe),
        .STATE_OUT(st), .SERIAL_ENABLE_OUT(ser_en), .ANALOG_SELECT_ENABLE_OUT(an_en),
        .SOURCES_ENABLE_OUT(src_en), .FAST_OSC_ENABLE_OUT(fosc), .SLOW_OSC_ENABLE_OUT(sosc),
        .FAULT_DETECT_ENABLE_OUT(fden), .PULL_DOWN_OUT(pdn), .SWITCH_CLOSED_OUT(closed),
        .POLL_ACTIVE_OUT(pact), .WAKE_REPORT_OUT(wrep), .INT_TIMER_WAKE_OUT(itw),
        .THERMAL_LIMIT_FAULT_OUT(tlf), .THERMAL_WARNING_OUT(twf), .FAULT_FLAGS_OUT(ff),
        .SUSTAIN_ACTIVE_OUT(sus), .WETTING_LEVEL_OUT(wout));
    // ground inputs read closed when low; battery-switch inputs when high
    function automatic logic [NB-1:0] exp_closed(input logic [NB-1:0] hi,
        input logic [NUM_PROG_INPUTS-1:0] b);
        logic [NB-1:0] r;
        r = ~hi;
        for (int j = 0; j < NUM_PROG_INPUTS; j++)
            r[NG+j] = b[j] ? hi[NG+j] : ~hi[NG+j];
        return r;
    endfunction : exp_closed
    task automatic wrap_up();
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    // bounded wait, sampled mid-cycle so edge updates have landed
    task automatic wait_state(input logic [2:0] s, input int lim);
        int k;
        k = 0;
        @(negedge clk);
        while (st !== s && k < lim)
        begin
            @(negedge clk);
            k++;
        end
        chk(s, st);
    endtask : wait_state
    task automatic low_power_mode();
        @(posedge clk);
        lpm_req <= 1'b1;
        @(posedge clk);
        lpm_req <= 1'b0;
        wait_state(SMPM_LOW_POWER, 6);
    endtask : low_power_mode
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            fails++;
            wrap_up();
        end
    end
    initial
    begin
        void'($urandom(66));
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({SMPM_RESET, 1'b0}, {st, woe});
        @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(negedge clk);
        chk({SMPM_RESET, 1'b0}, {st, sosc});
        @(posedge clk);
        por <= 1'b0;
        wait_state(SMPM_UV_LOCK, 5);
        chk(3'b000, {ser_en, an_en, src_en});
        chk(2'b11, {fosc, sosc});
        @(posedge clk);
        bat <= 1'b1;
        wait_state(SMPM_FUSE_READ, 5);
        repeat (FC - 3) @(negedge clk);
        chk(SMPM_FUSE_READ, st);
        wait_state(SMPM_NORMAL, 8);
        chk(2'b10, {woe, wdrv});
        chk(2'b11, {fden, ser_en});
        repeat (5)
        begin
            @(posedge clk);
            chi <= NB'({$urandom(), $urandom()});
            bsw <= NUM_PROG_INPUTS'($urandom());
            wet <= 4'($urandom());
            repeat (4) @(negedge clk);
            chk(exp_closed(chi, bsw), closed);
            chk({bsw, {NG{1'b0}}}, pdn);
            chk(wet, wout);
        end
        @(posedge clk);
        ov <= 1'b1;
        twarn <= 1'b1;
        @(posedge clk);
        ov <= 1'b0;
        repeat (3) @(negedge clk);
        chk({5'h18, 2'b01}, {ff, tlf, twf});
        @(posedge clk);
        tcell <= 1'b1;
        repeat (3) @(negedge clk);
        chk({1'b1, WET_REDUCED}, {tlf, wout});
        @(posedge clk);
        tcell <= 1'b0;
        repeat (3) @(negedge clk);
        chk(1'b1, tlf);
        @(posedge clk);
        tclr <= 1'b1;
        repeat (3) @(negedge clk);
        chk({1'b0, wet}, {tlf, wout});
        @(posedge clk);
        tclr <= 1'b0;
        chi <= '1;
        low_power_mode();
        chk(3'b000, {woe, fosc, fden});
        @(posedge clk);
        serr <= 1'b1;
        @(posedge clk);
        serr <= 1'b0;
        wlow <= 1'b1;
        wait_state(SMPM_NORMAL, 5000);
        chk(3'b101, {wrep, ff[1], woe});
        @(posedge clk);
        wlow <= 1'b0;
        low_power_mode();
        @(posedge clk);
        io <= 1'b0;
        clow <= 1'b1;
        wait_state(SMPM_SUPPLY_CHECK, 5000);
        wait_state(SMPM_LOW_POWER, 50);
        chk(1'b0, wrep);
        @(posedge clk);
        clow <= 1'b0;
        wlow <= 1'b1;
        repeat (4000) @(negedge clk);
        chk(SMPM_LOW_POWER, st);
        @(posedge clk);
        wlow <= 1'b0;
        repeat (4000) @(posedge clk);
        sck <= 1'b1;
        wlow <= 1'b1;
        wait_state(SMPM_NORMAL, 5000);
        @(posedge clk);
        wlow <= 1'b0;
        io <= 1'b1;
        sck <= 1'b0;
        itk <= 16'h0002;
        ptk <= 16'h0002;
        low_power_mode();
        wait_state(SMPM_NORMAL, 6000);
        chk(2'b10, {itw, pact});
        @(posedge clk);
        itk <= 16'h0000;
        ptk <= 16'h0001;
        low_power_mode();
        n = 0;
        while (pact !== 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        chk(2'b11, {pact, src_en});
        wait_state(SMPM_LOW_POWER, 8000);
        @(posedge clk);
        bat <= 1'b0;
        repeat (4000) @(negedge clk);
        chk(2'b00, {pact, st == SMPM_NORMAL});
        @(posedge clk);
        bat <= 1'b1;
        ptk <= 16'h0000;
        conly[0] <= 1'b1;
        chi[0] <= 1'b0;
        wait_state(SMPM_NORMAL, 5000);
        chk(1'b1, sus);
        repeat (SC + 5) @(negedge clk);
        chk(1'b0, sus);
        @(posedge clk);
        wen <= '0;
        ptk <= 16'h0001;
        low_power_mode();
        @(posedge clk);
        chi[0] <= 1'b1;
        n = 0;
        repeat (4000)
        begin
            @(negedge clk);
            n += int'(pact);
        end
        chk({32'd0, SMPM_LOW_POWER}, {n, st});
        @(posedge clk);
        ilow <= 1'b1;
        wait_state(SMPM_NORMAL, 5000);
        chk(1'b1, wrep);
        wrap_up();
    end
endmodule : smpm_power_fsm_tb_top
